//--- stfs_map.svh
`ifndef STFS_MAP_SVH
`define STFS_MAP_SVH
`define STFS_CLK_MHZ        50
`define STFS_HOT_NS         5000
`define STFS_BAT_NS         3500
`define STFS_PUMP_NS        4000
`define STFS_AR_US          64000
`define STFS_HOT_CYC        ((`STFS_HOT_NS * `STFS_CLK_MHZ + 999) / 1000)
`define STFS_BAT_CYC        ((`STFS_BAT_NS * `STFS_CLK_MHZ + 999) / 1000)
`define STFS_PUMP_CYC       ((`STFS_PUMP_NS * `STFS_CLK_MHZ + 999) / 1000)
`define STFS_AR_CYC         (`STFS_AR_US * `STFS_CLK_MHZ)
`define STFS_NCH            4
`define STFS_A_CTRL         12'h000
`define STFS_A_QSTAT        12'h004
`define STFS_A_CHST0        12'h008
`define STFS_A_STEP         4
`define STFS_A_DSTAT        12'h018
`define STFS_A_RAW          12'h01C
`define STFS_B_PUMP         4
`define STFS_B_SUM          5
`define STFS_B_MODE         8
`define STFS_B_LOW          0
`define STFS_B_HIGH         1
`define STFS_B_HOT          0
`define STFS_B_ON           1
`define STFS_RESP_OK        2'b00
`define STFS_RESP_ERR       2'b10
`endif

//--- stfs_pkg.sv
package stfs_pkg;
	typedef enum logic [1:0] {
		STFS_IDLE,
		STFS_RESP
	} stfs_bus_t;
endpackage : stfs_pkg

//--- stfs_top.sv
`timescale 1ns/1ps
`include "stfs_map.svh"
module stfs_top #(
	parameter int unsigned AR_CYCLES = `STFS_AR_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [3:0]  overtemp_raw,
	input  wire logic        battery_low_raw,
	input  wire logic        battery_high_raw,
	input  wire logic        pump_invalid_raw,
	input  wire logic        fail_mode,
	output logic [3:0]       out_enable,
	output logic [3:0]       inrush_restart
);
	import stfs_pkg::*;

	localparam int NCH = `STFS_NCH;
	localparam logic [15:0] HOT_TC  = 16'(`STFS_HOT_CYC);
	localparam logic [15:0] BAT_TC  = 16'(`STFS_BAT_CYC);
	localparam logic [15:0] PUMP_TC = 16'(`STFS_PUMP_CYC);
	localparam logic [31:0] AR_TC   = 32'(AR_CYCLES);

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] raw_in;
	assign raw_in = {fail_mode, pump_invalid_raw, battery_high_raw, battery_low_raw, overtemp_raw};
	// Two-stage sync of all fault and mode pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end
	logic [3:0] ot_s;
	logic       low_s;
	logic       high_s;
	logic       pump_s;
	logic       fail_s;
	assign ot_s   = sync2_reg[3:0];
	assign low_s  = sync2_reg[4];
	assign high_s = sync2_reg[5];
	assign pump_s = sync2_reg[6];
	assign fail_s = sync2_reg[7];

	////////////////////////////////////////////////////////////////
	// Deglitch filters: index 0..3 overtemp, 4 low, 5 pump
	logic [5:0] flt_in;
	logic [5:0] flt_ok;
	assign flt_in = {pump_s, low_s, ot_s};
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_flt
			logic [15:0] cnt_reg;
			logic [15:0] tc;
			assign tc = (g < NCH) ? HOT_TC : ((g == NCH) ? BAT_TC : PUMP_TC);
			always_ff @(posedge aclk) begin
				if (!aresetn)
					cnt_reg <= 16'h0000;
				else if (!flt_in[g])
					cnt_reg <= 16'h0000;
				else if (cnt_reg != tc)
					cnt_reg <= cnt_reg + 16'h0001;
			end
			assign flt_ok[g] = (cnt_reg == tc);
		end
	endgenerate
	logic [3:0] hot_ev;
	logic       low_ev;
	logic       pump_ev;
	// Filter outputs stay high while the raw fault stays steady
	assign hot_ev  = flt_ok[3:0];
	assign low_ev  = flt_ok[4];
	assign pump_ev = flt_ok[5];

	////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	stfs_bus_t  wst_reg;
	stfs_bus_t  rst_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_have_reg;
	logic        w_have_reg;
	logic        wr_fire;
	logic        rd_fire;
	logic [11:0] rd_addr;
	assign s_axi_awready = (wst_reg == STFS_IDLE) && !aw_have_reg;
	assign s_axi_wready  = (wst_reg == STFS_IDLE) && !w_have_reg;
	assign s_axi_arready = (rst_reg == STFS_IDLE);
	assign wr_fire = (wst_reg == STFS_IDLE) && aw_have_reg && w_have_reg;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;
	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
		end else if (wr_fire) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				// Strobes kept with the data; the master may drop them once taken
				wstrb_reg  <= s_axi_wstrb;
			end
		end
	end
	logic wr_ctrl;
	assign wr_ctrl = wr_fire && (awaddr_reg == `STFS_A_CTRL);
	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_reg     <= STFS_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `STFS_RESP_OK;
		end else begin
			unique case (wst_reg)
				STFS_IDLE: begin
					if (wr_fire) begin
						wst_reg      <= STFS_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= (awaddr_reg == `STFS_A_CTRL) ? `STFS_RESP_OK
							: `STFS_RESP_ERR;
					end
				end
				STFS_RESP: begin
					if (s_axi_bready) begin
						wst_reg      <= STFS_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Fault flags and output control
	logic [3:0] hot_flag_reg;
	logic       low_flag_reg;
	logic       high_flag_reg;
	logic       pump_flag_reg;
	logic [3:0] on_cmd_reg;
	logic [3:0] hot_lock_reg;
	logic       low_lock_reg;
	logic       fail_prev_reg;
	logic [31:0] ar_cnt_reg;
	logic       on_wr;
	logic       summary;
	logic [3:0] rd_chst;
	logic       rd_q;
	logic       rd_d;
	logic       mode_edge;
	logic       ar_fire;
	assign summary   = low_flag_reg | high_flag_reg | pump_flag_reg;
	assign rd_q      = rd_fire && (rd_addr == `STFS_A_QSTAT);
	assign rd_d      = rd_fire && (rd_addr == `STFS_A_DSTAT);
	assign mode_edge = fail_s != fail_prev_reg;
	assign ar_fire   = fail_s && (ar_cnt_reg == AR_TC - 32'h1);
	// Control write whose low byte carries the ON bits
	assign on_wr     = wr_ctrl && wstrb_reg[0];
	generate
		for (g = 0; g < NCH; g++) begin : g_rd
			assign rd_chst[g] = rd_fire
				&& (rd_addr == 12'(`STFS_A_CHST0 + `STFS_A_STEP * g));
		end
	endgenerate

	// Status flags: set wins over read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hot_flag_reg  <= 4'h0;
			low_flag_reg  <= 1'b0;
			high_flag_reg <= 1'b0;
			pump_flag_reg <= 1'b0;
		end else begin
			hot_flag_reg <= hot_ev | (hot_flag_reg & ~(rd_chst & ~ot_s));
			low_flag_reg <= low_ev | (low_flag_reg & ~(rd_d & !low_s));
			high_flag_reg <= high_s | (high_flag_reg & ~(rd_d & !high_s));
			pump_flag_reg <= pump_ev | (pump_flag_reg & ~(rd_q & !pump_s));
		end
	end

	// Autorestart timer, Fail mode only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_cnt_reg    <= 32'h0;
			fail_prev_reg <= 1'b0;
		end else begin
			fail_prev_reg <= fail_s;
			if (!fail_s || !low_lock_reg || ar_fire)
				ar_cnt_reg <= 32'h0;
			else
				ar_cnt_reg <= ar_cnt_reg + 32'h1;
		end
	end

	// ON commands and shutdown locks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_cmd_reg   <= 4'h0;
			hot_lock_reg <= 4'h0;
			low_lock_reg <= 1'b0;
		end else begin
			if (on_wr)
				on_cmd_reg <= wdata_reg[3:0];
			// per-channel lock
			// A lock outlives the fault, so a stale ON bit cannot restart it
			for (int i = 0; i < NCH; i++) begin
				if (hot_ev[i])
					hot_lock_reg[i] <= 1'b1;
				else if (fail_s ? mode_edge
					: (on_wr && wdata_reg[i] && !ot_s[i]))
					hot_lock_reg[i] <= 1'b0;
				else if (mode_edge)
					hot_lock_reg[i] <= 1'b0;
			end
			// global low lock
			// In Normal mode any nonzero ON write re-arms all outputs once the supply is back; Fail mode waits for the autorestart
			if (low_ev)
				low_lock_reg <= 1'b1;
			else if (fail_s ? (ar_fire && !low_s)
				: (on_wr && (wdata_reg[3:0] != 4'h0) && !low_s))
				low_lock_reg <= 1'b0;
		end
	end

	// Output drive and inrush restart pulse
	logic [3:0] en_next;
	always_comb begin
		// pump fault gates all outputs
		// Filter outputs gate too, so shutdown does not wait for the lock
		en_next = (pump_ev || low_ev || low_lock_reg) ? 4'h0
			: (on_cmd_reg & ~hot_lock_reg & ~hot_ev);
	end
	// Registered drive; a turn-on starts a fresh inrush window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_enable     <= 4'h0;
			inrush_restart <= 4'h0;
		end else begin
			out_enable    <= en_next;
			inrush_restart <= en_next & ~out_enable;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read channel
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h00000000;
		if (rd_addr == `STFS_A_CTRL)
			rd_val[3:0] = on_cmd_reg;
		else if (rd_addr == `STFS_A_QSTAT) begin
			rd_val[3:0] = hot_flag_reg;
			rd_val[`STFS_B_PUMP] = pump_flag_reg;
			rd_val[`STFS_B_SUM]  = summary;
			rd_val[`STFS_B_MODE] = fail_s;
		end else if (rd_addr == `STFS_A_DSTAT) begin
			rd_val[`STFS_B_LOW]  = low_flag_reg;
			rd_val[`STFS_B_HIGH] = high_flag_reg;
			rd_val[`STFS_B_SUM]  = summary;
		end else if (rd_addr == `STFS_A_RAW)
			rd_val[3:0] = out_enable;
		else begin
			for (int i = 0; i < NCH; i++) begin
				if (rd_addr == 12'(`STFS_A_CHST0 + `STFS_A_STEP * i)) begin
					rd_val[`STFS_B_HOT] = hot_flag_reg[i];
					rd_val[`STFS_B_ON]  = out_enable[i];
					rd_val[`STFS_B_SUM] = summary;
				end
			end
		end
	end
	logic rd_ok;
	assign rd_ok = (rd_addr == `STFS_A_CTRL) || (rd_addr == `STFS_A_QSTAT)
		|| (rd_addr == `STFS_A_DSTAT) || (rd_addr == `STFS_A_RAW) || (rd_chst != 4'h0);
	// Read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_reg      <= STFS_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `STFS_RESP_OK;
		end else begin
			unique case (rst_reg)
				STFS_IDLE: begin
					if (rd_fire) begin
						rst_reg      <= STFS_RESP;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata  <= rd_val;
						s_axi_rresp  <= rd_ok ? `STFS_RESP_OK : `STFS_RESP_ERR;
					end
				end
				STFS_RESP: begin
					if (s_axi_rready) begin
						rst_reg      <= STFS_IDLE;
						s_axi_rvalid <= 1'b0;
					end
				end
			endcase
		end
	end
endmodule : stfs_top

//--- stfs_chk.sv
`timescale 1ns/1ps
`include "stfs_map.svh"
module stfs_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0]  overtemp_raw,
	input wire logic        battery_low_raw,
	input wire logic        battery_high_raw,
	input wire logic        pump_invalid_raw,
	input wire logic [3:0]  out_enable,
	input wire logic [3:0]  inrush_restart
);
	// Margins cover input sync, deglitch count and output register
	localparam int OT = `STFS_HOT_CYC + 8;
	localparam int LO = `STFS_BAT_CYC + 8;
	localparam int PU = `STFS_PUMP_CYC + 8;
	logic [9:0]  ot_reg, lo_reg, hi_reg, pu_reg;
	logic [11:0] ar_reg;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	function automatic logic [9:0] run(input logic [9:0] c, input logic x);
		return !x ? 10'h000 : (&c ? c : c + 10'h001);
	endfunction : run
	// Steady-high run lengths and the address of the read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{ot_reg, lo_reg, hi_reg, pu_reg, ar_reg} <= '0;
		end else begin
			ot_reg <= run(ot_reg, |overtemp_raw && $stable(overtemp_raw));
			lo_reg <= run(lo_reg, battery_low_raw);
			hi_reg <= run(hi_reg, battery_high_raw);
			pu_reg <= run(pu_reg, pump_invalid_raw);
			if (s_axi_arvalid && s_axi_arready)
				ar_reg <= s_axi_araddr;
		end
	end
	sequence s_rd(logic [11:0] a);
		s_axi_rvalid && ar_reg == a;
	endsequence
	a_hot_ch_off: assert property (ot_reg >= OT |-> (out_enable & overtemp_raw) == 4'h0)
		else $error("Hot channel still on");
	a_hot_flag_set: assert property (s_rd(`STFS_A_QSTAT) ##0 ot_reg >= OT
		|-> (s_axi_rdata[3:0] & overtemp_raw) == overtemp_raw)
		else $error("Overtemp flag missing");
	a_low_all_off: assert property (lo_reg >= LO |-> out_enable == 4'h0)
		else $error("Output on in undervoltage");
	a_low_flag_set: assert property (s_rd(`STFS_A_DSTAT) ##0 lo_reg >= LO
		|-> s_axi_rdata[0] && s_axi_rdata[5])
		else $error("Battery low flag missing");
	a_high_flag_set: assert property (s_rd(`STFS_A_DSTAT) ##0 hi_reg >= 10'd8
		|-> s_axi_rdata[1] && s_axi_rdata[5])
		else $error("Battery high flag missing");
	a_pump_all_off: assert property (pu_reg >= PU |-> out_enable == 4'h0)
		else $error("Output on in pump fault");
	a_pump_flag_set: assert property (s_rd(`STFS_A_QSTAT) ##0 pu_reg >= PU
		|-> s_axi_rdata[4] && s_axi_rdata[5])
		else $error("Pump fail flag missing");
	a_turn_on_fresh: assert property ($rose(out_enable[0]) |-> ##[0:1] inrush_restart[0])
		else $error("Turn-on without inrush restart");
endmodule : stfs_chk

bind stfs_top stfs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .overtemp_raw(overtemp_raw),
	.battery_low_raw(battery_low_raw), .battery_high_raw(battery_high_raw),
	.pump_invalid_raw(pump_invalid_raw), .out_enable(out_enable),
	.inrush_restart(inrush_restart));

//--- stfs_mcu.sv
`timescale 1ns/1ps
// Controller-side bus master; dly holds a request back
module stfs_mcu (
	input wire logic        aclk,
	output logic [11:0]     awaddr,
	output logic            awvalid,
	input wire logic        awready,
	output logic [31:0]     wdata,
	output logic [3:0]      wstrb,
	output logic            wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	output logic            bready,
	output logic [11:0]     araddr,
	output logic            arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	output logic            rready
);
	// Idle bus from time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
	end
	// Both write channels offered, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input int dly,
		output logic [1:0] r);
		repeat (dly + 1) @(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// Read address held until taken, data taken with rvalid
	task automatic rd(input logic [11:0] a, input int dly, output logic [31:0] d,
		output logic [1:0] r);
		repeat (dly + 1) @(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : stfs_mcu

//--- test_supply_thermal_fault_supervisor.sv
`timescale 1ns/1ps
`include "stfs_map.svh"
module test_supply_thermal_fault_supervisor;
	localparam int AR = 100;
	localparam int OT = `STFS_HOT_CYC + 10;
	localparam int LO = `STFS_BAT_CYC + 10;
	localparam int PU = `STFS_PUMP_CYC + 10;
	logic [11:0] awaddr, araddr, ca;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, ot_raw, out_en, inrush, pat, pk;
	logic [1:0]  bresp, rresp, r;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, low_raw, high_raw, pump_raw, fail;
	int          errors, checked, cyc, k;
	integer      seed;
	// Clock
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;
	stfs_top #(.AR_CYCLES(AR)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .overtemp_raw(ot_raw),
		.battery_low_raw(low_raw), .battery_high_raw(high_raw),
		.pump_invalid_raw(pump_raw), .fail_mode(fail), .out_enable(out_en),
		.inrush_restart(inrush));
	stfs_mcu u_mcu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	////////////////////////////////////////////////////////////////
	task complete_run;
		$display("Checks %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task chk(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		u_mcu.rd(a, {$random(seed)} % 3, d, r);
		chk({r, d & m}, {`STFS_RESP_OK, e});
	endtask : rc
	task ctl(input logic [3:0] p);
		u_mcu.wr(`STFS_A_CTRL, {28'h0, p}, {$random(seed)} % 3, r);
		chk({32'h0, r}, {32'h0, `STFS_RESP_OK});
	endtask : ctl
	task oe(input logic [3:0] e);
		chk({30'h0, out_en}, {30'h0, e});
	endtask : oe
	task w(input int n);
		repeat (n) @(posedge aclk);
	endtask : w
	// Enabled set once channel c is shut down
	function automatic logic [3:0] drop(input logic [3:0] p, input int c);
		return p & ~(4'h1 << c);
	endfunction : drop
	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'h3EBA;
		{aresetn, low_raw, high_raw, fail, ot_raw} = 8'h00;
		pump_raw = 1'b1;
		w(3);
		aresetn <= 1'b1;
		k = {$random(seed)} % 4;
		d = $random(seed);
		pat = d[3:0] | 4'h1 | (4'h1 << k);
		pk = drop(pat, k);
		ca = `STFS_A_CHST0 + 12'(k * 4);
		rc(`STFS_A_CTRL, 32'hFFFFFFFF, 32'h0);
		u_mcu.rd(12'h100, 0, d, r);
		chk({r, d}, {`STFS_RESP_ERR, 32'h0});
		u_mcu.wr(`STFS_A_DSTAT, 32'h3, 1, r);
		chk({32'h0, r}, {32'h0, `STFS_RESP_ERR});
		w(PU);
		ctl(4'hF);
		w(10);
		oe(4'h0);
		rc(`STFS_A_QSTAT, 32'h30, 32'h30);
		pump_raw <= 1'b0;
		w(10);
		oe(4'hF);
		rc(`STFS_A_QSTAT, 32'h10, 32'h10);
		rc(`STFS_A_QSTAT, 32'h30, 32'h0);
		ctl(pat);
		ot_raw[k] <= 1'b1;
		w(OT / 2);
		ot_raw <= 4'h0;
		w(2);
		ot_raw[k] <= 1'b1;
		w(OT / 2);
		oe(pat);
		w(OT);
		oe(pk);
		rc(`STFS_A_QSTAT, 32'hF, 32'h1 << k);
		rc(ca, 32'h3, 32'h1);
		ot_raw <= 4'h0;
		w(10);
		oe(pk);
		rc(ca, 32'h1, 32'h1);
		rc(ca, 32'h1, 32'h0);
		ctl(pat);
		w(5);
		oe(pat);
		rc(`STFS_A_RAW, 32'hF, {28'h0, pat});
		low_raw <= 1'b1;
		w(LO);
		oe(4'h0);
		rc(`STFS_A_DSTAT, 32'h21, 32'h21);
		low_raw <= 1'b0;
		w(10);
		oe(4'h0);
		rc(`STFS_A_DSTAT, 32'h1, 32'h1);
		rc(`STFS_A_DSTAT, 32'h21, 32'h0);
		ctl(pat);
		w(5);
		oe(pat);
		high_raw <= 1'b1;
		w(10);
		rc(`STFS_A_DSTAT, 32'h22, 32'h22);
		high_raw <= 1'b0;
		w(5);
		rc(`STFS_A_DSTAT, 32'h2, 32'h2);
		rc(`STFS_A_DSTAT, 32'h2, 32'h0);
		fail <= 1'b1;
		w(5);
		ot_raw[k] <= 1'b1;
		w(OT);
		ot_raw <= 4'h0;
		w(5);
		ctl(pat);
		w(5);
		oe(pk);
		rc(`STFS_A_QSTAT, 32'h100, 32'h100);
		fail <= 1'b0;
		w(10);
		oe(pat);
		fail <= 1'b1;
		low_raw <= 1'b1;
		w(LO);
		oe(4'h0);
		low_raw <= 1'b0;
		w(5);
		ctl(pat);
		w(AR / 2 - 10);
		oe(4'h0);
		for (int i = 0; i < 3 * AR && out_en !== pat; i++) @(posedge aclk);
		oe(pat);
		complete_run;
	end
endmodule : test_supply_thermal_fault_supervisor
